// ---- mux_bus_and_io_ports.sv ----
// multiplexed address/data bus engine with on-chip ports, timer bytes and ram
//
// Contract
// - address strobe marks low address; latch on fall
// - address strobe every fifth clock, stops in standby
// - data strobe on every transfer, internal included
// - data strobe continuous outside standby; idle cycles are dummy reads
// - direction set before data strobe; low writes
// - direction rests high when not writing
// - upper address held on dedicated lines
// - address space follows the address width
// - muxed lines: address, then data per direction
// - bus cycle is clock divided by five
// - interrupt input takes low level and pulses
// - fetch flag high during opcode fetch strobe
// - fetch flag low while servicing interrupts
// - direction bit one outputs, zero inputs
// - output bits read back their latch
// - input bits read live pin state
// - reset clears directions, keeps data latches
// - port write always loads latch
// - direction registers readable and writable
// - low 128 addresses decode as internal, except unused offsets 02-03, 06-07 and 0a-0f
// - internal writes also run on the bus
// - internal reads ignore external bus data
// - masked interrupt request stays latched
`timescale 1ns/10ps
module mux_bus_and_io_ports
  import mux_bus_pkg::*;
(
  input  wire logic                           clk_sys,
  input  wire logic                           rst_n,
  // processor side, classic wishbone, 8-bit data
  input  wire logic                           wb_cyc,
  input  wire logic                           wb_stb,
  input  wire logic                           wb_we,
  input  wire logic                           wb_sel,
  input  wire logic [mux_bus_pkg::ADDR_W-1:0] wb_adr,
  input  wire logic [7:0]                     wb_dat_i,
  output logic      [7:0]                     wb_dat_o,
  output logic                                wb_ack,
  // core status, same clock
  input  wire logic                           fetch_req,
  input  wire logic                           irq_service,
  input  wire logic                           irq_mask,
  input  wire logic                           irq_taken,
  input  wire logic                           standby,
  output logic                                irq_request,
  // external bus
  output logic                                addr_latch_strobe,
  output logic                                transfer_strobe,
  output logic                                read_not_write,
  output logic                                opcode_fetch_flag,
  output logic [mux_bus_pkg::UPPER_W-1:0]     upper_addr_lines,
  input  wire logic [7:0]                     muxed_addr_data_lines_in,
  output logic [7:0]                          muxed_addr_data_lines_out,
  output logic [7:0]                          muxed_addr_data_lines_oe,
  input  wire logic                           irq_n,
  // ports
  input  wire logic [7:0]                     first_port_pins_in,
  output logic [7:0]                          first_port_pins_out,
  output logic [7:0]                          first_port_pins_oe,
  input  wire logic [7:0]                     second_port_pins_in,
  output logic [7:0]                          second_port_pins_out,
  output logic [7:0]                          second_port_pins_oe
);
  import mux_bus_pkg::*;

  phase_t             phase;
  phase_t             next_phase;
  logic [ADDR_W-1:0]  cur_addr;
  logic [7:0]         cur_wdata;
  logic               cur_write;
  logic               cur_owned;
  logic               cur_fetch;
  logic [7:0]         dir_a;
  logic [7:0]         dir_b;
  logic [7:0]         latch_a;
  logic [7:0]         latch_b;
  logic [7:0]         tmr_data;
  logic [7:0]         tmr_ctrl;
  logic [7:0]         ram [0:RAM_BYTES-1];
  logic [7:0]         bus_s1;
  logic [7:0]         bus_s2;
  logic [7:0]         pa_s1;
  logic [7:0]         pa_s2;
  logic [7:0]         pb_s1;
  logic [7:0]         pb_s2;
  logic               irq_s1;
  logic               irq_s2;
  logic               irq_prev;
  logic               irq_latch;

  // cycle sequencing
  wire cycle_end  = (phase == PH_END) || (phase == PH_PARK);
  wire take_req   = cycle_end && !standby && !cur_owned && wb_cyc && wb_stb && !wb_ack;
  wire finish_own = (phase == PH_END) && cur_owned;

  always_comb begin
    case (phase)
      PH_AS:   next_phase = PH_ADDR;
      PH_ADDR: next_phase = PH_DS1;
      PH_DS1:  next_phase = PH_DS2;
      PH_DS2:  next_phase = PH_END;
      PH_END:  next_phase = standby ? PH_PARK : PH_AS;
      PH_PARK: next_phase = standby ? PH_PARK : PH_AS;
      default: next_phase = PH_AS;
    endcase
  end

  // next cycle's request: owned transfer or redundant read of last address
  wire [ADDR_W-1:0] next_addr  = take_req ? wb_adr : cur_addr;
  wire              next_write = take_req && wb_we && wb_sel;
  wire [7:0]        next_wdata = take_req ? wb_dat_i : cur_wdata;
  wire              next_fetch = take_req && fetch_req && !wb_we;

  // internal decode of the current address
  wire       is_low   = cur_addr < ADDR_W'(INT_LIMIT);
  wire [6:0] low_ofs  = cur_addr[6:0];
  wire       hit_pa   = is_low && (low_ofs == PA_DATA_OFS);
  wire       hit_pb   = is_low && (low_ofs == PB_DATA_OFS);
  wire       hit_da   = is_low && (low_ofs == PA_DIR_OFS);
  wire       hit_db   = is_low && (low_ofs == PB_DIR_OFS);
  wire       hit_td   = is_low && (low_ofs == TMR_DATA_OFS);
  wire       hit_tc   = is_low && (low_ofs == TMR_CTRL_OFS);
  wire       hit_ram  = is_low && (low_ofs >= RAM_BASE);
  wire       internal = hit_pa | hit_pb | hit_da | hit_db | hit_td | hit_tc | hit_ram;
  wire [6:0] ram_idx  = 7'(low_ofs - RAM_BASE);

  // port read: output bits from latch, input bits live
  wire [7:0] port_a_rd = (latch_a & dir_a) | (pa_s2 & ~dir_a);
  wire [7:0] port_b_rd = (latch_b & dir_b) | (pb_s2 & ~dir_b);

  logic [7:0] int_rdata;
  always_comb begin
    int_rdata = BYTE_ZERO;
    if (hit_pa)       int_rdata = port_a_rd;
    else if (hit_pb)  int_rdata = port_b_rd;
    else if (hit_da)  int_rdata = dir_a;
    else if (hit_db)  int_rdata = dir_b;
    else if (hit_td)  int_rdata = tmr_data;
    else if (hit_tc)  int_rdata = tmr_ctrl;
    else if (hit_ram) int_rdata = ram[ram_idx];
  end

  wire [7:0] rd_result  = internal ? int_rdata : bus_s2;
  wire       int_wr     = finish_own && cur_write && internal;

  // pin view of the next phase
  wire       next_as    = (next_phase == PH_AS);
  wire       next_ds    = (next_phase == PH_DS1) || (next_phase == PH_DS2);
  wire       next_live  = (next_phase != PH_PARK);
  wire       next_addrp = (next_phase == PH_AS) || (next_phase == PH_ADDR);
  wire       load_cycle = cycle_end && (next_phase == PH_AS);
  wire       wr_eff     = load_cycle ? next_write : cur_write;
  wire       fetch_eff  = load_cycle ? next_fetch : cur_fetch;
  wire [ADDR_W-1:0] addr_eff  = load_cycle ? next_addr : cur_addr;
  wire [7:0]        wdata_eff = load_cycle ? next_wdata : cur_wdata;
  wire       rw_next    = !(wr_eff && next_live);
  wire [7:0] mux_next   = next_addrp ? addr_eff[7:0] : wdata_eff;
  wire       mux_drive  = next_live && (next_addrp || wr_eff);
  wire       flag_next  = next_ds && fetch_eff && !irq_service;

  // interrupt capture
  wire irq_fall   = irq_prev && !irq_s2;
  wire next_latch = irq_fall || (irq_latch && !irq_taken);

  // synchronisers for pins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_s1 <= BYTE_ZERO;
      bus_s2 <= BYTE_ZERO;
      pa_s1  <= BYTE_ZERO;
      pa_s2  <= BYTE_ZERO;
      pb_s1  <= BYTE_ZERO;
      pb_s2  <= BYTE_ZERO;
      irq_s1 <= 1'b1;
      irq_s2 <= 1'b1;
    end else begin
      bus_s1 <= muxed_addr_data_lines_in;
      bus_s2 <= bus_s1;
      pa_s1  <= first_port_pins_in;
      pa_s2  <= pa_s1;
      pb_s1  <= second_port_pins_in;
      pb_s2  <= pb_s1;
      irq_s1 <= irq_n;
      irq_s2 <= irq_s1;
    end
  end

  // cycle state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase     <= PH_END;
      cur_addr  <= ADDR_RESET;
      cur_wdata <= BYTE_ZERO;
      cur_write <= 1'b0;
      cur_owned <= 1'b0;
      cur_fetch <= 1'b0;
    end else begin
      phase <= next_phase;
      if (load_cycle) begin
        cur_addr  <= next_addr;
        cur_wdata <= next_wdata;
        cur_write <= next_write;
        cur_owned <= take_req;
        cur_fetch <= next_fetch;
      end else if (finish_own) begin
        cur_owned <= 1'b0;
        cur_write <= 1'b0;
        cur_fetch <= 1'b0;
      end
    end
  end

  // registered bus pins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      addr_latch_strobe         <= 1'b0;
      transfer_strobe           <= 1'b0;
      read_not_write            <= 1'b1;
      opcode_fetch_flag         <= 1'b0;
      upper_addr_lines          <= UPPER_W'(0);
      muxed_addr_data_lines_out <= BYTE_ZERO;
      muxed_addr_data_lines_oe  <= BYTE_ZERO;
    end else begin
      addr_latch_strobe         <= next_as;
      transfer_strobe           <= next_ds;
      read_not_write            <= rw_next;
      opcode_fetch_flag         <= flag_next;
      upper_addr_lines          <= addr_eff[ADDR_W-1:8];
      muxed_addr_data_lines_out <= mux_next;
      muxed_addr_data_lines_oe  <= {8{mux_drive}};
    end
  end

  // wishbone answer at the end of an owned cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack   <= 1'b0;
      wb_dat_o <= BYTE_ZERO;
    end else begin
      wb_ack <= finish_own;
      if (finish_own && !cur_write) wb_dat_o <= rd_result;
    end
  end

  // direction registers and interrupt latch, cleared by reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dir_a       <= DIR_RESET;
      dir_b       <= DIR_RESET;
      irq_prev    <= 1'b1;
      irq_latch   <= 1'b0;
      irq_request <= 1'b0;
    end else begin
      if (int_wr && hit_da) dir_a <= cur_wdata;
      if (int_wr && hit_db) dir_b <= cur_wdata;
      irq_prev    <= irq_s2;
      irq_latch   <= next_latch;
      irq_request <= (next_latch || !irq_s2) && !irq_mask;
    end
  end

  // data latches and memory keep contents across reset
  always_ff @(posedge clk_sys) begin
    if (int_wr && hit_pa) latch_a <= cur_wdata;
    if (int_wr && hit_pb) latch_b <= cur_wdata;
    if (int_wr && hit_td) tmr_data <= cur_wdata;
    if (int_wr && hit_tc) tmr_ctrl <= cur_wdata;
    if (int_wr && hit_ram) ram[ram_idx] <= cur_wdata;
  end

  // port pin drive per bit
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_port
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          first_port_pins_oe[gi]  <= 1'b0;
          second_port_pins_oe[gi] <= 1'b0;
        end else begin
          first_port_pins_oe[gi]  <= dir_a[gi];
          second_port_pins_oe[gi] <= dir_b[gi];
        end
      end
      always_ff @(posedge clk_sys) begin
        first_port_pins_out[gi]  <= latch_a[gi];
        second_port_pins_out[gi] <= latch_b[gi];
      end
    end
  endgenerate

endmodule : mux_bus_and_io_ports

// ---- mux_bus_pkg.sv ----
// constants for the multiplexed bus and port block
package mux_bus_pkg;

  // address width: 16 for the wide variant, 13 for the narrow one
  localparam int          ADDR_W      = 16;
  localparam int          UPPER_W     = ADDR_W - 8;
  localparam int          SPACE_BYTES = 1 << ADDR_W;

  // bus cycle is the oscillator divided by five
  localparam int          BUS_DIV     = 5;
  localparam int          CLK_NS      = 25;
  localparam int          BUS_CYC_NS  = BUS_DIV * CLK_NS;

  // internal space is the low 128 addresses
  localparam logic [15:0] INT_LIMIT   = 16'h0080;
  localparam logic [6:0]  PA_DATA_OFS = 7'h00;
  localparam logic [6:0]  PB_DATA_OFS = 7'h01;
  localparam logic [6:0]  PA_DIR_OFS  = 7'h04;
  localparam logic [6:0]  PB_DIR_OFS  = 7'h05;
  localparam logic [6:0]  TMR_DATA_OFS = 7'h08;
  localparam logic [6:0]  TMR_CTRL_OFS = 7'h09;
  localparam logic [6:0]  RAM_BASE    = 7'h10;
  localparam int          RAM_BYTES   = 112;

  // values after reset
  localparam logic [7:0]  DIR_RESET   = 8'h00;
  localparam logic [15:0] ADDR_RESET  = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;

  typedef enum logic [2:0] {
    PH_AS,
    PH_ADDR,
    PH_DS1,
    PH_DS2,
    PH_END,
    PH_PARK
  } phase_t;

endpackage : mux_bus_pkg

// ---- mux_bus_chk.sv ----
// concurrent checks on the external bus pins of the bus and port block
`timescale 1ns/10ps
module mux_bus_chk (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       standby,
  input wire logic       irq_service,
  input wire logic       addr_latch_strobe,
  input wire logic       transfer_strobe,
  input wire logic       read_not_write,
  input wire logic       opcode_fetch_flag,
  input wire logic [7:0] muxed_addr_data_lines_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_as_per; addr_latch_strobe && !standby ##1 !standby[*5] |-> addr_latch_strobe; endproperty
  a_as_per: assert property (p_as_per) else $error("address strobe period wrong");
  property p_as_len; addr_latch_strobe |=> !addr_latch_strobe[*4]; endproperty
  a_as_len: assert property (p_as_len) else $error("address strobe too long");
  property p_ds; $rose(addr_latch_strobe) |-> ##2 transfer_strobe[*2] ##1 !transfer_strobe; endproperty
  a_ds: assert property (p_ds) else $error("data strobe misplaced");
  property p_rw; $rose(addr_latch_strobe) |=> $stable(read_not_write)[*4]; endproperty
  a_rw: assert property (p_rw) else $error("direction moved in cycle");
  property p_oe; transfer_strobe |-> muxed_addr_data_lines_oe == {8{!read_not_write}}; endproperty
  a_oe: assert property (p_oe) else $error("data phase drive wrong");
  property p_park;
    standby[*8] |-> read_not_write && !transfer_strobe && muxed_addr_data_lines_oe == 8'h00;
  endproperty
  a_park: assert property (p_park) else $error("bus not parked");
  property p_flag; opcode_fetch_flag |-> transfer_strobe; endproperty
  a_flag: assert property (p_flag) else $error("fetch flag outside strobe");
  property p_isr; irq_service[*2] |-> !opcode_fetch_flag; endproperty
  a_isr: assert property (p_isr) else $error("fetch flag during service");
endmodule : mux_bus_chk
bind mux_bus_and_io_ports mux_bus_chk u_mux_bus_chk (.clk_sys, .rst_n, .standby, .irq_service,
  .addr_latch_strobe, .transfer_strobe, .read_not_write, .opcode_fetch_flag, .muxed_addr_data_lines_oe);

// ---- ext_mem_model.sv ----
// far-side memory on the multiplexed bus; also resolves the bus level
`timescale 1ns/10ps
module ext_mem_model
  import mux_bus_pkg::*;
(
  input  wire logic                            clk_sys,
  input  wire logic                            addr_latch_strobe,
  input  wire logic                            transfer_strobe,
  input  wire logic                            read_not_write,
  input  wire logic [mux_bus_pkg::UPPER_W-1:0] upper_addr_lines,
  input  wire logic [7:0]                      bus_out,
  input  wire logic [7:0]                      bus_oe,
  output logic      [7:0]                      bus_level
);
  logic [7:0]        mem [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] lat = '0;
  logic [7:0]        rd_data = 8'h00;
  logic [7:0]        idle_pat = 8'h3c;
  always @(negedge addr_latch_strobe) lat = {upper_addr_lines, bus_out};
  always @(negedge transfer_strobe) if (!read_not_write) mem[lat] = bus_out;
  always @(posedge clk_sys) begin
    rd_data  <= mem.exists(lat) ? mem[lat] : lat[7:0] ^ 8'ha5;
    idle_pat <= ~idle_pat ^ 8'h01;
  end
  // released lines wander, so stale data never passes
  assign bus_level = bus_oe[0] ? bus_out : (transfer_strobe && read_not_write ? rd_data : idle_pat);
endmodule : ext_mem_model

// ---- tb_mux_bus_and_io_ports.sv ----
// self-checking bench for the multiplexed bus and port block
`timescale 1ns/10ps
module tb_mux_bus_and_io_ports;
  import mux_bus_pkg::*;
  logic               clk_sys = 0, rst_n = 0, wb_cyc = 0, wb_we = 0, wb_sel = 0, fetch_req = 0;
  logic               irq_service = 0, irq_mask = 1, irq_taken = 0, standby = 0, irq_n = 1;
  logic [15:0]        wb_adr = 16'h0000;
  logic [7:0]         wb_dat_i = 8'h00, pa_drv = 8'h00, pb_drv = 8'h00, wb_dat_o;
  logic [UPPER_W-1:0] upper_addr_lines;
  logic [7:0]         muxed_addr_data_lines_in, muxed_addr_data_lines_out, muxed_addr_data_lines_oe;
  logic [7:0]         first_port_pins_in, first_port_pins_out, first_port_pins_oe;
  logic [7:0]         second_port_pins_in, second_port_pins_out, second_port_pins_oe;
  logic               wb_ack, irq_request, addr_latch_strobe, transfer_strobe, read_not_write, opcode_fetch_flag;
  wire                wb_stb = wb_cyc;
  logic [7:0]         exp_q[$];
  logic [15:0]        ext[4] = '{16'h0002, 16'h0080, 16'h1fff, 16'hffff};
  int                 errors = 0, samples_checked = 0, flags = 0;
  mux_bus_and_io_ports u_mux_bus_and_io_ports (.clk_sys, .rst_n, .wb_cyc, .wb_stb, .wb_we, .wb_sel, .wb_adr,
    .wb_dat_i, .wb_dat_o, .wb_ack, .fetch_req, .irq_service, .irq_mask, .irq_taken, .standby, .irq_request,
    .addr_latch_strobe, .transfer_strobe, .read_not_write, .opcode_fetch_flag, .upper_addr_lines,
    .muxed_addr_data_lines_in, .muxed_addr_data_lines_out, .muxed_addr_data_lines_oe, .irq_n,
    .first_port_pins_in, .first_port_pins_out, .first_port_pins_oe, .second_port_pins_in,
    .second_port_pins_out, .second_port_pins_oe);
  // fetch flag clocks seen, two per fetch cycle
  always @(posedge clk_sys) flags += int'(opcode_fetch_flag === 1'b1);
  ext_mem_model u_ext_mem_model (.clk_sys, .addr_latch_strobe, .transfer_strobe, .read_not_write,
    .upper_addr_lines, .bus_out(muxed_addr_data_lines_out), .bus_oe(muxed_addr_data_lines_oe),
    .bus_level(muxed_addr_data_lines_in));
  assign first_port_pins_in  = (first_port_pins_oe & first_port_pins_out) | (~first_port_pins_oe & pa_drv);
  assign second_port_pins_in = (second_port_pins_oe & second_port_pins_out) | (~second_port_pins_oe & pb_drv);
  always #12.5 clk_sys = ~clk_sys;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  task automatic wb(input logic we, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    wb_cyc   <= 1'b1;
    wb_we    <= we;
    wb_sel   <= 1'b1;
    wb_adr   <= a;
    wb_dat_i <= d;
    do @(posedge clk_sys); while (wb_ack !== 1'b1 && ++n < 40);
    if (n == 40) begin
      chk("ack", 8'h01, 8'h00);
      print_verdict();
    end
    wb_cyc <= 1'b0;
    @(posedge clk_sys);
  endtask : wb
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 8'h00);
  endtask : rd
  // read results are matched in order of issue
  always @(posedge clk_sys)
    if (wb_ack === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0) chk("rdata", exp_q.pop_front(), wb_dat_o);
  initial begin
    #100000;
    chk("watchdog", 8'h01, 8'h00);
    print_verdict();
  end
  initial begin
    logic [7:0]  d, m, pv;
    logic [15:0] a, da;
    int          n;
    d = $urandom(48);
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    for (int p = 0; p < 2; p++) begin
      da = {9'h000, p ? PB_DATA_OFS : PA_DATA_OFS};
      a  = {9'h000, p ? PB_DIR_OFS : PA_DIR_OFS};
      d  = $urandom;
      m  = $urandom;
      pv = $urandom;
      if (p) pb_drv <= pv;
      else pa_drv <= pv;
      rd(a, DIR_RESET);
      wb(1'b1, da, d);
      rd(da, pv);
      wb(1'b1, a, m);
      rd(a, m);
      rd(da, (d & m) | (pv & ~m));
      chk("port_oe", m, p ? second_port_pins_oe : first_port_pins_oe);
      chk("port_out", d, p ? second_port_pins_out : first_port_pins_out);
    end
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk("latch_kept", d, second_port_pins_out);
    chk("dir_cleared", DIR_RESET, second_port_pins_oe);
    for (int i = 0; i < 4; i++) begin
      a = {9'h000, RAM_BASE} + 16'($urandom_range(RAM_BYTES - 1));
      d = $urandom;
      wb(1'b1, a, d);
      chk("mirror", d, u_ext_mem_model.mem[a]);
      u_ext_mem_model.mem[a] = ~d;
      rd(a, d);
    end
    foreach (ext[i]) begin
      d = $urandom;
      wb(1'b1, ext[i], d);
      fetch_req <= i[0];
      rd(ext[i], d);
      fetch_req <= 1'b0;
    end
    chk("fetch_flag", 8'd4, 8'(flags));
    for (int s = 0; s < 2; s++) begin
      standby <= s[0];
      repeat (10) @(posedge clk_sys);
      n = 0;
      repeat (50) begin
        @(posedge clk_sys);
        n += int'(addr_latch_strobe === 1'b1);
      end
      chk("strobes", s ? 8'd0 : 8'd10, 8'(n));
    end
    standby     <= 1'b0;
    irq_service <= 1'b1;
    wb(1'b1, 16'h0012, 8'h5a);
    fetch_req <= 1'b1;
    rd(16'h0012, 8'h5a);
    fetch_req <= 1'b0;
    chk("fetch_in_service", 8'd4, 8'(flags));
    irq_n       <= 1'b0;
    repeat (2) @(posedge clk_sys);
    irq_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk("irq_masked", 8'h00, {7'h00, irq_request});
    irq_mask <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("irq_held", 8'h01, {7'h00, irq_request});
    irq_taken <= 1'b1;
    @(posedge clk_sys);
    irq_taken <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("irq_clear", 8'h00, {7'h00, irq_request});
    irq_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk("irq_level", 8'h01, {7'h00, irq_request});
    irq_n <= 1'b1;
    print_verdict();
  end
endmodule : tb_mux_bus_and_io_ports
